/* File: hdl/ape_event_logic.sv */
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Legacy route enable steers events to management interrupt.
// - ACPI route enable steers events to control interrupt.
// - Management interrupt: dedicated pin or serial IRQ.
// - Control interrupt: dedicated pin, selected IRQ, serial.
// - Firmware release sets global status; status clears both.
// - OS release sets firmware status; status clears both.
// - Bus master request sets status; status clears both.
// - Wrapping 24-bit up counter on timer clock.
// - Timer top bit change sets carry status.
// - Enabled carry status raises control interrupt.
// - Timer count readable through three registers.
// - Timer counts only while run enable set.
// - Timer runs after power-up without software.
// - Event status and enable are 16 bits.
// - Events set status always; enable gates interrupt.
// - Status bits set by hardware, cleared writing one.
// - Enable bit shares its status bit position; the bus master enable sits in control register bit 1 instead.
// - Unimplemented enable bits read zero, ignore writes.
// - Unimplemented control bits read zero, ignore writes.
// - Status register placed before enable register.
// - Three base registers decode event and GPE blocks.
// - Carry bit 0, bus master 4, global 5.
module ape_event_logic (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data channels.
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response channel.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels.
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Timer clock pin, sampled as an ordinary input.
	input wire logic pm_timer_clk,
	// Host I/O address for block decode.
	input wire logic [15:0] io_addr,
	output logic event_block_hit,
	output logic gpe0_block_hit,
	output logic gpe1_block_hit,
	// Interrupt outputs.
	output logic smi_out_n,
	output logic sci_out_n,
	output logic [ape_pkg::IRQ_LINES-1:0] irq_request,
	output logic serial_irq_smi,
	output logic serial_irq_sci
);
	// ------------------------------------------------------------------
	// State.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] aw_addr; // Held write address.
		logic aw_full; // Write address taken, not yet used.
		logic [31:0] w_data; // Held write data.
		logic [3:0] w_strb; // Held byte strobes.
		logic w_full; // Write data taken, not yet used.
		logic bvalid; // Write response pending.
		logic [1:0] bresp; // Write response code.
		logic rvalid; // Read response pending.
		logic [31:0] rdata; // Read response data.
		logic [1:0] rresp; // Read response code.
		logic timer_carry_status; // Timer top bit changed.
		logic busmaster_event_status; // Bus master event seen.
		logic global_event_status; // Firmware wants the OS.
		logic timer_carry_enable; // Carry raises control interrupt.
		logic global_event_enable; // Global status raises interrupt.
		logic acpi_route_enable; // Route events to control interrupt.
		logic busmaster_wake_enable; // Bus master raises interrupt.
		logic os_release; // OS wants firmware attention.
		logic busmaster_request; // Bus master request.
		logic timer_run_enable; // Timer counting allowed.
		logic legacy_route_enable; // Route events to management irq.
		logic firmware_event_enable; // OS release raises management irq.
		logic firmware_event_status; // OS wants firmware attention.
		logic firmware_release; // Firmware wants OS attention.
		logic serial_irq_mode; // Interrupts leave on serial IRQ.
		logic [ape_pkg::IRQ_SEL_W-1:0] irq_select; // Control irq line.
		logic [15:0] event_block_base; // Event block I/O base.
		logic [15:0] gpe0_base; // GPE block 0 I/O base.
		logic [15:0] gpe1_base; // GPE block 1 I/O base.
		logic [ape_pkg::TMR_W-1:0] timer_count; // Timer value.
		logic pm_clk_prev; // Previous synchronised timer clock.
		logic smi_n; // Dedicated management interrupt pin.
		logic sci_n; // Dedicated control interrupt pin.
		logic ser_smi; // Management request to serial IRQ.
		logic ser_sci; // Control request to serial IRQ.
		logic [ape_pkg::IRQ_LINES-1:0] irq_req; // IRQ request lines.
		logic hit_evt; // Address falls in event block.
		logic hit_g0; // Address falls in GPE block 0.
		logic hit_g1; // Address falls in GPE block 1.
	} ape_state_t;
	ape_state_t st_reg;
	ape_state_t st_next;
	logic pm_clk_sync; // Synchronised timer clock level.
	// ------------------------------------------------------------------
	// Timer clock synchroniser.
	// ------------------------------------------------------------------
	ape_sync u_pm_clk_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(pm_timer_clk),
		.sync_out(pm_clk_sync)
	);
	// ------------------------------------------------------------------
	// Read multiplexer.
	// ------------------------------------------------------------------
	// Build the word seen at a byte offset; reserved bits stay zero.
	function automatic logic [31:0] read_word(input ape_state_t s,
		input logic [7:0] a);
		logic [31:0] d;
		d = 32'h00000000;
		unique case (a)
			ape_pkg::OFF_EVT_STATUS: begin // Status first, 16 bits.
				d[ape_pkg::BIT_TIMER_CARRY] = s.timer_carry_status;
				d[ape_pkg::BIT_BUSMASTER] = s.busmaster_event_status;
				d[ape_pkg::BIT_GLOBAL] = s.global_event_status;
			end
			ape_pkg::OFF_EVT_ENABLE: begin
				// Same positions as status; other bits read zero.
				d[ape_pkg::BIT_TIMER_CARRY] = s.timer_carry_enable;
				d[ape_pkg::BIT_GLOBAL] = s.global_event_enable;
			end
			ape_pkg::OFF_PM_CONTROL: begin
				// Unimplemented control bits read zero.
				d[ape_pkg::BIT_ACPI_ROUTE] = s.acpi_route_enable;
				d[ape_pkg::BIT_BM_WAKE] = s.busmaster_wake_enable;
				d[ape_pkg::BIT_OS_RELEASE] = s.os_release;
				d[ape_pkg::BIT_BM_REQUEST] = s.busmaster_request;
			end
			ape_pkg::OFF_TIMER_LOW: d[7:0] = s.timer_count[7:0];
			ape_pkg::OFF_TIMER_MID: d[7:0] = s.timer_count[15:8];
			ape_pkg::OFF_TIMER_HIGH: d[7:0] = s.timer_count[23:16];
			ape_pkg::OFF_GPE0_CONTROL: d[ape_pkg::BIT_TIMER_RUN] = s.timer_run_enable;
			ape_pkg::OFF_FIRMWARE: begin
				d[ape_pkg::BIT_LEGACY_ROUTE] = s.legacy_route_enable;
				d[ape_pkg::BIT_FW_ENABLE] = s.firmware_event_enable;
				d[ape_pkg::BIT_FW_STATUS] = s.firmware_event_status;
				d[ape_pkg::BIT_FW_RELEASE] = s.firmware_release;
				d[ape_pkg::BIT_SERIAL_MODE] = s.serial_irq_mode;
				d[ape_pkg::BIT_IRQ_SEL_LO +: ape_pkg::IRQ_SEL_W] = s.irq_select;
			end
			ape_pkg::OFF_EVENT_BLOCK_BASE: d[15:0] = s.event_block_base;
			ape_pkg::OFF_GPE0_BASE: d[15:0] = s.gpe0_base;
			ape_pkg::OFF_GPE1_BASE: d[15:0] = s.gpe1_base;
			default: d = 32'h00000000;
		endcase
		return d;
	endfunction
	// Tell whether a byte offset holds a register.
	function automatic logic is_mapped(input logic [7:0] a);
		logic m;
		m = 1'b0;
		unique case (a)
			ape_pkg::OFF_EVT_STATUS, ape_pkg::OFF_EVT_ENABLE,
			ape_pkg::OFF_PM_CONTROL, ape_pkg::OFF_TIMER_LOW,
			ape_pkg::OFF_TIMER_MID, ape_pkg::OFF_TIMER_HIGH,
			ape_pkg::OFF_GPE0_CONTROL, ape_pkg::OFF_FIRMWARE,
			ape_pkg::OFF_EVENT_BLOCK_BASE, ape_pkg::OFF_GPE0_BASE,
			ape_pkg::OFF_GPE1_BASE: m = 1'b1;
			default: m = 1'b0;
		endcase
		return m;
	endfunction
	// ------------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------------
	// Bus slave, register effects, timer and interrupt routing.
	always_comb begin
		logic [31:0] wd; // Write data with unstrobed bytes cleared.
		logic do_write; // A write happens this cycle.
		logic [ape_pkg::TMR_W-1:0] cnt; // Timer value after this cycle.
		logic carry_set; // Timer top bit toggles this cycle.
		logic carry_clr; // Software clears the carry status.
		logic sci_event; // Control-class event is pending.
		logic smi_event; // Management-class event is pending.
		logic sci_req; // Control interrupt asserted.
		logic smi_req; // Management interrupt asserted.
		wd = 32'h00000000;
		do_write = 1'b0;
		cnt = st_reg.timer_count;
		carry_set = 1'b0;
		carry_clr = 1'b0;
		sci_event = 1'b0;
		smi_event = 1'b0;
		sci_req = 1'b0;
		smi_req = 1'b0;
		st_next = st_reg;
		// Take write address and data independently.
		if (s_axi_awvalid && !st_reg.aw_full) begin
			st_next.aw_addr = s_axi_awaddr[7:0];
			st_next.aw_full = 1'b1;
		end
		if (s_axi_wvalid && !st_reg.w_full) begin
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
			st_next.w_full = 1'b1;
		end
		// Retire a write response once accepted.
		if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;
		do_write = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
		for (int i = 0; i < 4; i++) begin
			wd[i*8 +: 8] = st_reg.w_strb[i] ? st_reg.w_data[i*8 +: 8] : 8'h00;
		end
		// Apply the write; only implemented bits take effect.
		if (do_write) begin
			st_next.aw_full = 1'b0;
			st_next.w_full = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = is_mapped(st_reg.aw_addr) ? ape_pkg::RESP_OKAY :
				ape_pkg::RESP_SLVERR;
			unique case (st_reg.aw_addr)
				ape_pkg::OFF_EVT_STATUS: begin
					// Writing one clears; writing zero leaves alone.
					carry_clr = wd[ape_pkg::BIT_TIMER_CARRY];
					if (wd[ape_pkg::BIT_BUSMASTER]) begin
						st_next.busmaster_event_status = 1'b0;
						st_next.busmaster_request = 1'b0;
					end
					if (wd[ape_pkg::BIT_GLOBAL]) begin
						st_next.global_event_status = 1'b0;
						st_next.firmware_release = 1'b0;
					end
				end
				ape_pkg::OFF_EVT_ENABLE: begin
					st_next.timer_carry_enable = wd[ape_pkg::BIT_TIMER_CARRY];
					st_next.global_event_enable = wd[ape_pkg::BIT_GLOBAL];
				end
				ape_pkg::OFF_PM_CONTROL: begin
					st_next.acpi_route_enable = wd[ape_pkg::BIT_ACPI_ROUTE];
					st_next.busmaster_wake_enable = wd[ape_pkg::BIT_BM_WAKE];
					if (wd[ape_pkg::BIT_OS_RELEASE]) begin
						st_next.os_release = 1'b1;
						st_next.firmware_event_status = 1'b1;
					end
					if (wd[ape_pkg::BIT_BM_REQUEST]) begin
						st_next.busmaster_request = 1'b1;
						st_next.busmaster_event_status = 1'b1;
					end
				end
				ape_pkg::OFF_GPE0_CONTROL: begin
					st_next.timer_run_enable = wd[ape_pkg::BIT_TIMER_RUN];
				end
				ape_pkg::OFF_FIRMWARE: begin
					st_next.legacy_route_enable = wd[ape_pkg::BIT_LEGACY_ROUTE];
					st_next.firmware_event_enable = wd[ape_pkg::BIT_FW_ENABLE];
					st_next.serial_irq_mode = wd[ape_pkg::BIT_SERIAL_MODE];
					st_next.irq_select =
						wd[ape_pkg::BIT_IRQ_SEL_LO +: ape_pkg::IRQ_SEL_W];
					if (wd[ape_pkg::BIT_FW_STATUS]) begin
						st_next.firmware_event_status = 1'b0;
						st_next.os_release = 1'b0;
					end
					if (wd[ape_pkg::BIT_FW_RELEASE]) begin
						st_next.firmware_release = 1'b1;
						st_next.global_event_status = 1'b1;
					end
				end
				ape_pkg::OFF_EVENT_BLOCK_BASE: st_next.event_block_base = wd[15:0];
				ape_pkg::OFF_GPE0_BASE: st_next.gpe0_base = wd[15:0];
				ape_pkg::OFF_GPE1_BASE: st_next.gpe1_base = wd[15:0];
				default: ; // Read-only or unmapped: no effect.
			endcase
		end
		// Answer a read one cycle after the address is taken.
		if (st_reg.rvalid && s_axi_rready) st_next.rvalid = 1'b0;
		if (s_axi_arvalid && !st_reg.rvalid) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = read_word(st_reg, s_axi_araddr[7:0]);
			st_next.rresp = is_mapped(s_axi_araddr[7:0]) ? ape_pkg::RESP_OKAY :
				ape_pkg::RESP_SLVERR;
		end
		// Count rising edges of the timer clock while enabled.
		st_next.pm_clk_prev = pm_clk_sync;
		if (pm_clk_sync && !st_reg.pm_clk_prev &&
			st_reg.timer_run_enable) begin
			cnt = st_reg.timer_count + 1'b1; // Wraps through zero.
		end
		st_next.timer_count = cnt;
		// Either direction of the top bit counts.
		carry_set = cnt[ape_pkg::TMR_W-1] ^
			st_reg.timer_count[ape_pkg::TMR_W-1];
		// A carry in the clearing cycle is kept.
		st_next.timer_carry_status =
			(st_reg.timer_carry_status && !carry_clr) || carry_set;
		// Status is visible always; enables gate the events.
		sci_event = (st_reg.timer_carry_status &&
			st_reg.timer_carry_enable) ||
			(st_reg.firmware_release && st_reg.global_event_enable) ||
			(st_reg.busmaster_request && st_reg.busmaster_wake_enable);
		smi_event = st_reg.os_release && st_reg.firmware_event_enable;
		sci_req = st_reg.acpi_route_enable && sci_event;
		smi_req = smi_event ||
			(st_reg.legacy_route_enable && sci_event);
		// Send each interrupt to the serial IRQ or its pins.
		st_next.ser_smi = st_reg.serial_irq_mode && smi_req;
		st_next.smi_n = !(!st_reg.serial_irq_mode && smi_req);
		st_next.ser_sci = st_reg.serial_irq_mode && sci_req;
		st_next.sci_n = !(!st_reg.serial_irq_mode && sci_req &&
			st_reg.irq_select == '0);
		st_next.irq_req = '0;
		if (!st_reg.serial_irq_mode && sci_req && st_reg.irq_select != '0) begin
			st_next.irq_req[st_reg.irq_select] = 1'b1;
		end
		// Decode host I/O addresses against the three bases.
		st_next.hit_evt = (st_reg.event_block_base != ape_pkg::RST_BASE) &&
			((io_addr & ~ape_pkg::EVT_BLOCK_MASK) ==
			(st_reg.event_block_base & ~ape_pkg::EVT_BLOCK_MASK));
		st_next.hit_g0 = (st_reg.gpe0_base != ape_pkg::RST_BASE) &&
			((io_addr & ~ape_pkg::GPE_BLOCK_MASK) ==
			(st_reg.gpe0_base & ~ape_pkg::GPE_BLOCK_MASK));
		st_next.hit_g1 = (st_reg.gpe1_base != ape_pkg::RST_BASE) &&
			((io_addr & ~ape_pkg::GPE_BLOCK_MASK) ==
			(st_reg.gpe1_base & ~ape_pkg::GPE_BLOCK_MASK));
	end
	// ------------------------------------------------------------------
	// State register.
	// ------------------------------------------------------------------
	// Reset clears everything but starts the timer running and sets both dedicated interrupt pins high.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
			st_reg.timer_run_enable <= ape_pkg::RST_TIMER_RUN;
			st_reg.timer_count <= ape_pkg::RST_TIMER;
			st_reg.smi_n <= 1'b1;
			st_reg.sci_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end
	// ------------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------------
	assign s_axi_awready = !st_reg.aw_full;
	assign s_axi_wready = !st_reg.w_full;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;
	assign event_block_hit = st_reg.hit_evt;
	assign gpe0_block_hit = st_reg.hit_g0;
	assign gpe1_block_hit = st_reg.hit_g1;
	assign smi_out_n = st_reg.smi_n;
	assign sci_out_n = st_reg.sci_n;
	assign irq_request = st_reg.irq_req;
	assign serial_irq_smi = st_reg.ser_smi;
	assign serial_irq_sci = st_reg.ser_sci;
endmodule // ape_event_logic

`default_nettype wire

/* File: hdl/ape_pkg.sv */
package ape_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets on the AXI4-Lite bus.
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_EVT_STATUS = 8'h00;
	localparam logic [7:0] OFF_EVT_ENABLE = 8'h04;
	localparam logic [7:0] OFF_PM_CONTROL = 8'h08;
	localparam logic [7:0] OFF_TIMER_LOW = 8'h0c;
	localparam logic [7:0] OFF_TIMER_MID = 8'h10;
	localparam logic [7:0] OFF_TIMER_HIGH = 8'h14;
	localparam logic [7:0] OFF_GPE0_CONTROL = 8'h18;
	localparam logic [7:0] OFF_FIRMWARE = 8'h1c;
	localparam logic [7:0] OFF_EVENT_BLOCK_BASE = 8'h20;
	localparam logic [7:0] OFF_GPE0_BASE = 8'h24;
	localparam logic [7:0] OFF_GPE1_BASE = 8'h28;

	// ------------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------------
	// Event status and event enable registers.
	localparam int BIT_TIMER_CARRY = 0;
	localparam int BIT_BUSMASTER = 4;
	localparam int BIT_GLOBAL = 5;
	// Power management control register.
	localparam int BIT_ACPI_ROUTE = 0;
	localparam int BIT_BM_WAKE = 1;
	localparam int BIT_OS_RELEASE = 2;
	localparam int BIT_BM_REQUEST = 3;
	// General-purpose event block 0 control register.
	localparam int BIT_TIMER_RUN = 0;
	// Firmware register.
	localparam int BIT_LEGACY_ROUTE = 0;
	localparam int BIT_FW_ENABLE = 1;
	localparam int BIT_FW_STATUS = 2;
	localparam int BIT_FW_RELEASE = 3;
	localparam int BIT_SERIAL_MODE = 4;
	localparam int BIT_IRQ_SEL_LO = 8;

	// ------------------------------------------------------------------
	// Widths, sizes and values after reset.
	// ------------------------------------------------------------------
	localparam int EVT_W = 16;
	localparam int TMR_W = 24;
	localparam int IRQ_SEL_W = 4;
	localparam int IRQ_LINES = 16;
	localparam int SYNC_STAGES = 2;
	localparam logic [15:0] EVT_BLOCK_MASK = 16'h000f;
	localparam logic [15:0] GPE_BLOCK_MASK = 16'h0003;
	localparam logic RST_TIMER_RUN = 1'b1;
	localparam logic [TMR_W-1:0] RST_TIMER = 24'h000000;
	localparam logic [15:0] RST_BASE = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Nominal rate of the timer clock pin, in hertz.
	localparam real PM_CLK_HZ = 3579545.0;

endpackage

/* File: hdl/ape_sync.sv */
`timescale 1ns/100ps
`default_nettype none

// Two-stage synchroniser for a level arriving from outside the clock domain.
module ape_sync (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Asynchronous level in, synchronised level out.
	input wire logic async_in,
	output logic sync_out
);

	// ------------------------------------------------------------------
	// State.
	// ------------------------------------------------------------------
	typedef struct packed {
		logic stage1; // First stage, read only by the second stage.
		logic stage2; // Second stage, safe to use.
	} ape_sync_t;

	ape_sync_t st_reg;
	ape_sync_t st_next;

	// Shift the input through both stages.
	always_comb begin
		st_next = st_reg;
		st_next.stage1 = async_in;
		st_next.stage2 = st_reg.stage1;
	end

	// Register the state, clearing it on reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.stage2;

endmodule // ape_sync

`default_nettype wire

/* File: test/ape_event_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Port checker for the event logic.
// ------------------------------------------------------------------
module ape_event_monitor (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes.
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// Interrupt outputs.
	input wire logic smi_out_n,
	input wire logic sci_out_n,
	input wire logic [ape_pkg::IRQ_LINES-1:0] irq_request,
	input wire logic serial_irq_smi,
	input wire logic serial_irq_sci
);
	// All checks share the bus clock and its reset.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Serial requests leave the dedicated pins idle.
	property p_smi_serial;
		serial_irq_smi |-> smi_out_n;
	endproperty
	a_smi_serial: assert property (p_smi_serial) else $error("smi pin busy in serial mode");
	property p_sci_serial;
		serial_irq_sci |-> sci_out_n && irq_request == 16'h0000;
	endproperty
	a_sci_serial: assert property (p_sci_serial) else $error("sci pins busy in serial mode");
	// At most one request line is chosen.
	property p_irq_onehot;
		$onehot0(irq_request);
	endproperty
	a_irq_onehot: assert property (p_irq_onehot) else $error("several irq lines");
	// The dedicated pin and the request lines exclude each other.
	property p_sci_excl;
		!sci_out_n |-> irq_request == 16'h0000;
	endproperty
	a_sci_excl: assert property (p_sci_excl) else $error("sci on two places");
	// A taken read is answered in the next cycle.
	property p_ar_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while pending");
	// One answer per transfer; no back-to-back repeats.
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read answer repeated");
	property p_b_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("write answer repeated");
	property p_bresp_code;
		s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10;
	endproperty
	a_bresp_code: assert property (p_bresp_code) else $error("bad write response");

	// Main scenarios.
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_smi: cover property (!smi_out_n);
	c_serial: cover property (serial_irq_sci);
endmodule // ape_event_monitor

`default_nettype wire

/* File: test/ape_pm_clk_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Timer clock source; stands low except while pulses are asked for.
// ------------------------------------------------------------------
module ape_pm_clk_model (
	// Bus clock used to pace the pulses.
	input wire logic aclk,
	// Timer clock pin.
	output logic pm_timer_clk
);
	initial pm_timer_clk = 1'b0;

	// Eleven bus cycles a period, close to the nominal timer rate.
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (5) @(posedge aclk);
			pm_timer_clk <= 1'b1;
			repeat (6) @(posedge aclk);
			pm_timer_clk <= 1'b0;
		end
	endtask
endmodule // ape_pm_clk_model

`default_nettype wire

/* File: test/ape_event_tb.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Register-level bench for the event logic.
// ------------------------------------------------------------------
module testbench;
	localparam logic [7:0] ST = ape_pkg::OFF_EVT_STATUS;
	localparam logic [7:0] EN = ape_pkg::OFF_EVT_ENABLE;
	localparam logic [7:0] PC = ape_pkg::OFF_PM_CONTROL;
	localparam logic [7:0] FW = ape_pkg::OFF_FIRMWARE;
	localparam logic [7:0] GC = ape_pkg::OFF_GPE0_CONTROL;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, pm_timer_clk;
	logic event_block_hit, gpe0_block_hit, gpe1_block_hit;
	logic smi_out_n, sci_out_n, serial_irq_smi, serial_irq_sci;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] io_addr, irq_request;
	logic [15:0] da [5] = '{16'h040f, 16'h0410, 16'h0503, 16'h0504, 16'h0602};
	logic [2:0] dh [5] = '{3'b100, 3'b000, 3'b010, 3'b000, 3'b001};
	int err_total = 0;
	int tests_run = 0;

	ape_event_logic u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pm_timer_clk, .io_addr,
		.event_block_hit, .gpe0_block_hit, .gpe1_block_hit, .smi_out_n,
		.sci_out_n, .irq_request, .serial_irq_smi, .serial_irq_sci);
	ape_pm_clk_model u_pm (.aclk, .pm_timer_clk);

	// Free-running bus clock.
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// Counts one comparison and reports a difference.
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Write with address and data offered together.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
		s_axi_awaddr <= {24'h000000, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask

	// Read and compare data and response.
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'b00);
		s_axi_araddr <= {24'h000000, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		chk($sformatf("reg %h", a), e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask

	// Interrupt pins as {smi_n, sci_n, irq lines, serial smi, serial sci}.
	task automatic pins(input logic [19:0] e);
		repeat (3) @(posedge aclk);
		chk("pins", {12'h0, e}, {12'h0, smi_out_n, sci_out_n, irq_request, serial_irq_smi, serial_irq_sci});
	endtask

	// Main sequence.
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hf;
		io_addr = 16'h0000;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ST, 32'h0);
		rd(GC, 32'h1);
		rd(FW, 32'h0);
		pins(20'hc0000);
		rd(8'h2c, 32'h0, 2'b10);
		wr(8'h2c, 32'hffffffff, 2'b10);
		wr(EN, 32'hffffffff);
		rd(EN, 32'h21);
		wr(PC, 32'hfffffff3);
		rd(PC, 32'h3);
		wr(FW, 32'h8);
		rd(ST, 32'h20);
		pins(20'h80000);
		wr(ST, 32'h0);
		rd(ST, 32'h20);
		wr(ST, 32'h20);
		rd(FW, 32'h0);
		pins(20'hc0000);
		wr(PC, 32'hb);
		rd(ST, 32'h10);
		pins(20'h80000);
		wr(PC, 32'h2);
		pins(20'hc0000);
		rd(ST, 32'h10);
		wr(FW, 32'h1);
		pins(20'h40000);
		wr(FW, 32'h11);
		pins(20'hc0002);
		wr(PC, 32'h3);
		pins(20'hc0003);
		wr(FW, 32'h501);
		pins(20'h40080);
		wr(ST, 32'h10);
		rd(PC, 32'h3);
		pins(20'hc0000);
		wr(FW, 32'h2);
		wr(PC, 32'h7);
		rd(FW, 32'h6);
		pins(20'h40000);
		wr(FW, 32'h6);
		rd(PC, 32'h3);
		pins(20'hc0000);
		chk("hits", 32'h0, {29'h0, event_block_hit, gpe0_block_hit, gpe1_block_hit});
		wr(ape_pkg::OFF_EVENT_BLOCK_BASE, 32'h0400);
		wr(ape_pkg::OFF_GPE0_BASE, 32'h0500);
		wr(ape_pkg::OFF_GPE1_BASE, 32'h0600);
		for (int i = 0; i < 5; i++) begin
			io_addr <= da[i];
			repeat (2) @(posedge aclk);
			chk("hits", {29'h0, dh[i]}, {29'h0, event_block_hit, gpe0_block_hit, gpe1_block_hit});
		end
		u_pm.pulses(5);
		repeat (6) @(posedge aclk);
		rd(ape_pkg::OFF_TIMER_LOW, 32'h5);
		wr(GC, 32'h0);
		u_pm.pulses(3);
		repeat (6) @(posedge aclk);
		rd(ape_pkg::OFF_TIMER_LOW, 32'h5);
		wr(GC, 32'h1);
		u_pm.pulses(256);
		repeat (6) @(posedge aclk);
		rd(ape_pkg::OFF_TIMER_LOW, 32'h5);
		rd(ape_pkg::OFF_TIMER_MID, 32'h1);
		rd(ape_pkg::OFF_TIMER_HIGH, 32'h0);
		tally_and_finish();
	end

	// Watchdog against a hung handshake.
	initial begin
		repeat (30000) @(posedge aclk);
		err_total++;
		tally_and_finish();
	end
endmodule // testbench

bind ape_event_logic ape_event_monitor u_mon (.aclk, .aresetn, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_bresp, .smi_out_n, .sci_out_n, .irq_request,
	.serial_irq_smi, .serial_irq_sci);

`default_nettype wire
